// ==== design/sdcb_pkg.sv ====
package sdcb_pkg;
  // clock rate and timing figures in ns
  localparam int CLK_MHZ   = 10;
  localparam int PRECH_NS  = 20;  // precharge_time
  localparam int ACT_NS    = 20;  // activate_to_access_time
  localparam int TRC_NS    = 70;  // auto refresh period
  localparam int SREX_NS   = 80;  // self_refresh_exit_time
  localparam int MLOAD_NS  = 20;  // mode_load_settle_time
  localparam int SREX_NOPS = 2;   // fewest no-ops after self-refresh exit

  // least time rounded up to whole cycles, never below one
  function automatic int min_cyc(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  // timer width and derived cycle counts
  localparam int               TMR_W    = 4;
  localparam logic [TMR_W-1:0] TMR_ONE   = 4'h1;
  localparam logic [TMR_W-1:0] PRECH_CYC = TMR_W'(min_cyc(PRECH_NS));
  localparam logic [TMR_W-1:0] ACT_CYC   = TMR_W'(min_cyc(ACT_NS));
  localparam logic [TMR_W-1:0] TRC_CYC   = TMR_W'(min_cyc(TRC_NS));
  localparam logic [TMR_W-1:0] MLOAD_CYC = TMR_W'(min_cyc(MLOAD_NS));
  localparam logic [TMR_W-1:0] SREX_CYC  =
    TMR_W'((min_cyc(SREX_NS) < SREX_NOPS) ? SREX_NOPS : min_cyc(SREX_NS));

  // array geometry and access shape
  localparam int BANKS     = 4;
  localparam int BANK_W    = 2;
  localparam int ADDR_W    = 12;
  localparam int COL_W     = 8;
  localparam int DQ_W      = 16;
  localparam int DQM_W     = 2;
  localparam int AP_BIT    = 10;
  localparam int BURST_LEN = 4;
  localparam int CAS_LAT   = 2;
  localparam logic [ADDR_W-1:0] MODE_RST = 12'h000;

  // commands, coded as {row strobe, column strobe, write strobe}
  typedef enum logic [2:0] {
    CMD_LMR = 3'h0,
    CMD_REF = 3'h1,
    CMD_PRE = 3'h2,
    CMD_ACT = 3'h3,
    CMD_WR  = 3'h4,
    CMD_RD  = 3'h5,
    CMD_BST = 3'h6,
    CMD_NOP = 3'h7
  } sdcb_cmd_t;

  // per bank state
  typedef enum logic [7:0] {
    BK_IDLE     = 8'h01,
    BK_ACTING   = 8'h02,
    BK_ACTIVE   = 8'h04,
    BK_READ     = 8'h08,
    BK_WRITE    = 8'h10,
    BK_READ_AP  = 8'h20,
    BK_WRITE_AP = 8'h40,
    BK_PRECH    = 8'h80
  } sdcb_bank_t;

  // device power state
  typedef enum logic [3:0] {
    PWR_RUN  = 4'h1,
    PWR_DOWN = 4'h2,
    PWR_SELF = 4'h4,
    PWR_SUSP = 4'h8
  } sdcb_pwr_t;

  // controller register map and fields
  localparam int              APB_AW       = 8;
  localparam logic [APB_AW-1:0] REG_CMD    = 8'h00;
  localparam logic [APB_AW-1:0] REG_ADDR   = 8'h04;
  localparam logic [APB_AW-1:0] REG_WDATA  = 8'h08;
  localparam logic [APB_AW-1:0] REG_CKE    = 8'h0C;
  localparam logic [APB_AW-1:0] REG_STAT   = 8'h10;
  localparam logic [APB_AW-1:0] REG_RDATA  = 8'h14;
  localparam int              CMD_BANK_LSB = 4;
  localparam int              CMD_SREF_BIT = 8;
  localparam int              WD_MASK_LSB  = 16;
  localparam int              ST_OPEN_LSB  = 4;
  localparam logic            CKE_RST      = 1'b1;
endpackage

// ==== design/sdcb_if.sv ====
`timescale 1ns/100ps
interface sdcb_if;
  // command pins, driven by the controller
  logic                          cs_n;
  logic                          ras_n;
  logic                          cas_n;
  logic                          we_n;
  logic                          cke;
  logic [sdcb_pkg::ADDR_W-1:0]   addr;
  logic [sdcb_pkg::BANK_W-1:0]   bank_select;
  logic [sdcb_pkg::DQM_W-1:0]    dqm;
  // data pins, one drive per end
  logic [sdcb_pkg::DQ_W-1:0]     ctl_dq;
  logic                          ctl_dq_oe;
  logic [sdcb_pkg::DQ_W-1:0]     dev_dq;
  logic [sdcb_pkg::DQM_W-1:0]    dev_dq_oe;
  wire  [sdcb_pkg::DQ_W-1:0]     dq;

  // resolve each byte lane of the shared data wires; a released lane reads as zero
  assign dq[7:0]  = ctl_dq_oe ? ctl_dq[7:0] : (dev_dq_oe[0] ? dev_dq[7:0] : 8'h00);
  assign dq[15:8] = ctl_dq_oe ? ctl_dq[15:8] : (dev_dq_oe[1] ? dev_dq[15:8] : 8'h00);

  modport dev (input cs_n, ras_n, cas_n, we_n, cke, addr, bank_select, dqm, dq,
               output dev_dq, dev_dq_oe);
  modport ctl (output cs_n, ras_n, cas_n, we_n, cke, addr, bank_select, dqm,
               ctl_dq, ctl_dq_oe, input dq);
endinterface

// ==== design/sdcb_dev.sv ====
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/100ps
module sdcb_dev #(
  parameter int BURST = sdcb_pkg::BURST_LEN
) (
  // clock and reset
  input  wire logic                          i_ref_clk,
  input  wire logic                          i_reset,
  // pins from the controller
  sdcb_if.dev                                bus,
  // array access strobe with address
  output logic                               o_wr_stb,
  output logic                               o_rd_stb,
  output logic [sdcb_pkg::BANK_W-1:0]        o_acc_bank,
  output logic [sdcb_pkg::ADDR_W-1:0]        o_acc_row,
  output logic [sdcb_pkg::COL_W-1:0]         o_acc_col,
  output logic [sdcb_pkg::DQ_W-1:0]          o_wr_data,
  output logic [sdcb_pkg::DQM_W-1:0]         o_wr_byte_en,
  // read data from the array, same cycle as o_rd_stb
  input  wire logic [sdcb_pkg::DQ_W-1:0]     i_rd_data,
  // refresh strobe and row
  output logic                               o_ref_stb,
  output logic [sdcb_pkg::ADDR_W-1:0]        o_ref_row,
  // status
  output logic [sdcb_pkg::ADDR_W-1:0]        o_mode,
  output sdcb_pkg::sdcb_pwr_t                o_pwr
);
  import sdcb_pkg::*;

  // true while a bank holds an open row that can take an access
  function automatic logic can_access(input sdcb_bank_t st);
    return (st == BK_ACTIVE) || (st == BK_READ) || (st == BK_WRITE);
  endfunction

  // true while a bank bursts with auto precharge pending
  function automatic logic is_ap(input sdcb_bank_t st);
    return (st == BK_READ_AP) || (st == BK_WRITE_AP);
  endfunction

  // state registers
  sdcb_bank_t              bank_r   [BANKS];  // per bank state
  sdcb_bank_t              bank_nxt [BANKS];
  logic [TMR_W-1:0]        btmr_r   [BANKS];  // per bank delay timer
  logic [TMR_W-1:0]        btmr_nxt [BANKS];
  logic [ADDR_W-1:0]       row_r    [BANKS];  // open row per bank
  sdcb_pwr_t               pwr_r;             // power state
  sdcb_pwr_t               pwr_nxt;
  logic                    cke_prev_r;        // enable seen at last edge
  logic [TMR_W-1:0]        gtmr_r;            // refresh, mode load, precharge all, self refresh exit
  logic [TMR_W-1:0]        gtmr_nxt;
  logic [ADDR_W-1:0]       mode_r;            // mode register
  logic [ADDR_W-1:0]       ref_row_r;         // internal refresh row counter
  logic                    all_idle;          // every bank idle
  // newest burst
  logic                    bst_on_r;
  logic                    bst_wr_r;
  logic [BANK_W-1:0]       bst_bank_r;
  logic [COL_W-1:0]        bst_col_r;
  logic [7:0]              bst_left_r;        // beats still to issue
  // read data path
  logic [DQM_W-1:0]        dqm_d_r;           // mask taken one edge earlier
  logic [DQ_W-1:0]         dq_o_r;
  logic [DQM_W-1:0]        dq_oe_r;
  // output registers
  logic                    wr_stb_r;
  logic                    rd_stb_r;
  logic [BANK_W-1:0]       acc_bank_r;
  logic [COL_W-1:0]        acc_col_r;
  logic [DQ_W-1:0]         wr_data_r;
  logic [DQM_W-1:0]        wr_be_r;
  logic                    ref_stb_r;

  sdcb_cmd_t cmd;
  assign cmd = bus.cs_n ? CMD_NOP : sdcb_cmd_t'({bus.ras_n, bus.cas_n, bus.we_n});

  // commands act only when enable high at both edges, except self refresh entry, taken on the edge where enable falls
  wire               run  = cke_prev_r & bus.cke & (pwr_r == PWR_RUN);
  wire               exec = run & (gtmr_r == '0);
  wire [BANK_W-1:0]  sel  = bus.bank_select;
  // bit ten picks auto precharge per access
  wire               ap   = bus.addr[AP_BIT];
  // access accepted only by a bank with an open row
  wire               acc  = exec & ((cmd == CMD_RD) | (cmd == CMD_WR)) & can_access(bank_r[sel]);
  wire               acc_wr = acc & (cmd == CMD_WR);
  // precharge all or the selected bank
  wire               pre_bst = exec & (cmd == CMD_PRE) & (ap | (sel == bst_bank_r));
  // terminate ends the newest burst whatever its bank
  wire               bst_cut = bst_on_r & run &
                               ((bst_left_r == 8'h00) | (exec & (cmd == CMD_BST)) | acc | pre_bst);
  wire               beat    = bst_on_r & run & ~bst_cut;
  wire               ref_go  = exec & (cmd == CMD_REF) & all_idle;
  wire               sref_go = cke_prev_r & ~bus.cke & (pwr_r == PWR_RUN) &
                               (gtmr_r == '0) & all_idle & (cmd == CMD_REF) & ~bst_on_r;

  // bank state and timer next values
  always_comb begin
    all_idle = 1'b1;
    for (int b = 0; b < BANKS; b++) begin
      all_idle    = all_idle & (bank_r[b] == BK_IDLE);
      bank_nxt[b] = bank_r[b];
      btmr_nxt[b] = (btmr_r[b] != '0) ? btmr_r[b] - TMR_ONE : btmr_r[b];
      // timed states finish when the timer runs out
      if (btmr_r[b] == TMR_ONE) begin
        if (bank_r[b] == BK_ACTING) begin
          bank_nxt[b] = BK_ACTIVE;
        end
        if (bank_r[b] == BK_PRECH) begin
          bank_nxt[b] = BK_IDLE;
        end
      end
      // burst over: reopen, or close the row if auto precharge was asked
      if (bst_cut && (bst_bank_r == BANK_W'(b))) begin
        if (is_ap(bank_r[b])) begin
          bank_nxt[b] = BK_PRECH;
          btmr_nxt[b] = PRECH_CYC;
        end else begin
          bank_nxt[b] = BK_ACTIVE;
        end
      end
      if (exec && (cmd == CMD_ACT) && (sel == BANK_W'(b)) && (bank_r[b] == BK_IDLE)) begin
        bank_nxt[b] = BK_ACTING;
        btmr_nxt[b] = ACT_CYC;
      end
      if (acc && (sel == BANK_W'(b))) begin
        if (acc_wr) begin
          bank_nxt[b] = ap ? BK_WRITE_AP : BK_WRITE;
        end else begin
          bank_nxt[b] = ap ? BK_READ_AP : BK_READ;
        end
      end
      // precharge leaves an idle bank alone
      if (exec && (cmd == CMD_PRE) && (ap || (sel == BANK_W'(b))) &&
          (bank_r[b] != BK_IDLE)) begin
        bank_nxt[b] = BK_PRECH;
        btmr_nxt[b] = PRECH_CYC;
      end
    end
  end

  // power state next value
  always_comb begin
    pwr_nxt = pwr_r;
    unique case (pwr_r)
      PWR_RUN: begin
        if (cke_prev_r && !bus.cke) begin
          if (bst_on_r) begin
            pwr_nxt = PWR_SUSP;
          end else if (all_idle && (gtmr_r == '0) && (cmd == CMD_NOP)) begin
            pwr_nxt = PWR_DOWN;
          end else if (sref_go) begin
            pwr_nxt = PWR_SELF;
          end
        end
      end
      // stay while enable low, leave when it rises
      PWR_DOWN, PWR_SUSP, PWR_SELF: begin
        if (bus.cke) begin
          pwr_nxt = PWR_RUN;
        end
      end
    endcase
  end

  // global timer next value
  always_comb begin
    gtmr_nxt = (gtmr_r != '0) ? gtmr_r - TMR_ONE : gtmr_r;
    if ((pwr_r == PWR_SELF) && bus.cke) begin
      gtmr_nxt = SREX_CYC;
    end else if (ref_go) begin
      gtmr_nxt = TRC_CYC;
    end else if (exec && (cmd == CMD_LMR) && all_idle) begin
      gtmr_nxt = MLOAD_CYC;
    end else if (exec && (cmd == CMD_PRE) && ap) begin
      gtmr_nxt = PRECH_CYC;
    end
  end

  // bank, power and mode registers
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      for (int b = 0; b < BANKS; b++) begin
        bank_r[b] <= BK_IDLE;
        btmr_r[b] <= '0;
        row_r[b]  <= '0;
      end
      pwr_r      <= PWR_RUN;
      cke_prev_r <= 1'b0;
      gtmr_r     <= '0;
      mode_r     <= MODE_RST;
      ref_row_r  <= '0;
      ref_stb_r  <= 1'b0;
    end else begin
      bank_r     <= bank_nxt;
      btmr_r     <= btmr_nxt;
      pwr_r      <= pwr_nxt;
      cke_prev_r <= bus.cke;
      gtmr_r     <= gtmr_nxt;
      ref_stb_r  <= ref_go;
      if (exec && (cmd == CMD_ACT) && (bank_r[sel] == BK_IDLE)) begin
        row_r[sel] <= bus.addr;
      end
      // op code from all address bits
      if (exec && (cmd == CMD_LMR) && all_idle) begin
        mode_r <= bus.addr;
      end
      // refresh row from the internal counter
      if (ref_go || sref_go) begin
        ref_row_r <= ref_row_r + 12'h001;
      end
    end
  end

  // newest burst tracking
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      bst_on_r   <= 1'b0;
      bst_wr_r   <= 1'b0;
      bst_bank_r <= '0;
      bst_col_r  <= '0;
      bst_left_r <= '0;
    end else if (acc) begin
      bst_on_r   <= 1'b1;
      bst_wr_r   <= acc_wr;
      bst_bank_r <= sel;
      bst_col_r  <= bus.addr[COL_W-1:0];
      bst_left_r <= 8'(BURST - 1);
    end else if (bst_cut) begin
      bst_on_r   <= 1'b0;
    end else if (beat) begin
      bst_col_r  <= bst_col_r + 8'h01;
      bst_left_r <= bst_left_r - 8'h01;
    end
  end

  // array strobes, one beat per edge
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      wr_stb_r   <= 1'b0;
      rd_stb_r   <= 1'b0;
      acc_bank_r <= '0;
      acc_col_r  <= '0;
      wr_data_r  <= '0;
      wr_be_r    <= '0;
    end else begin
      wr_stb_r   <= acc_wr | (beat & bst_wr_r);
      rd_stb_r   <= (acc & ~acc_wr) | (beat & ~bst_wr_r);
      acc_bank_r <= acc ? sel : bst_bank_r;
      acc_col_r  <= acc ? bus.addr[COL_W-1:0] : bst_col_r + 8'h01;
      wr_data_r  <= bus.dq;
      // high mask blocks the byte in the same cycle
      wr_be_r    <= ~bus.dqm;
    end
  end

  // read data drive
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      dqm_d_r <= '1;
      dq_o_r  <= '0;
      dq_oe_r <= '0;
    end else begin
      dqm_d_r <= bus.dqm;
      dq_o_r  <= i_rd_data;
      // mask taken two edges before the data is sampled
      dq_oe_r <= {DQM_W{rd_stb_r}} & ~dqm_d_r;
    end
  end

  // outputs
  assign o_wr_stb     = wr_stb_r;
  assign o_rd_stb     = rd_stb_r;
  assign o_acc_bank   = acc_bank_r;
  assign o_acc_row    = row_r[acc_bank_r];
  assign o_acc_col    = acc_col_r;
  assign o_wr_data    = wr_data_r;
  assign o_wr_byte_en = wr_be_r;
  assign o_ref_stb    = ref_stb_r;
  assign o_ref_row    = ref_row_r;
  assign o_mode       = mode_r;
  assign o_pwr        = pwr_r;
  assign bus.dev_dq    = dq_o_r;
  assign bus.dev_dq_oe = dq_oe_r;
endmodule

// ==== design/sdcb_ctl.sv ====
`timescale 1ns/100ps
module sdcb_ctl (
  // clock and reset
  input  wire logic                          i_ref_clk,
  input  wire logic                          i_reset,
  // apb slave
  input  wire logic                          i_psel,
  input  wire logic                          i_penable,
  input  wire logic                          i_pwrite,
  input  wire logic [sdcb_pkg::APB_AW-1:0]   i_paddr,
  input  wire logic [31:0]                   i_pwdata,
  output logic [31:0]                        o_prdata,
  output logic                               o_pready,
  output logic                               o_pslverr,
  // pins to the device
  sdcb_if.ctl                                bus
);
  import sdcb_pkg::*;

  // cycles to hold no-ops after each command
  function automatic logic [TMR_W-1:0] wait_of(input sdcb_cmd_t op, input logic apb);
    logic [TMR_W-1:0] w;
    w = TMR_ONE;
    unique case (op)
      CMD_ACT: w = ACT_CYC;
      CMD_RD:  w = TMR_W'(BURST_LEN + CAS_LAT + 1);
      CMD_WR:  w = TMR_W'(BURST_LEN);
      CMD_PRE: w = PRECH_CYC;
      CMD_REF: w = TRC_CYC;
      CMD_LMR: w = MLOAD_CYC;
      CMD_BST, CMD_NOP: w = TMR_ONE;
    endcase
    return (apb && ((op == CMD_RD) || (op == CMD_WR))) ? w + PRECH_CYC : w;
  endfunction

  // registers
  logic                 pready_r;
  logic                 pslverr_r;
  logic [31:0]          prdata_r;
  logic [ADDR_W-1:0]    addr_reg_r;   // address for next command
  logic [DQ_W-1:0]      wdata_r;      // write data
  logic [DQM_W-1:0]     mask_r;       // byte mask
  logic                 cke_r;        // clock enable pin
  logic                 sref_r;       // device in self refresh
  logic [BANKS-1:0]     open_r;       // banks with a row open
  logic [TMR_W-1:0]     wait_r;       // no-op hold count
  logic [2:0]           rd_sh_r;      // read return delay line
  logic [DQ_W-1:0]      rdata_r;
  logic                 rvalid_r;
  // pin registers
  sdcb_cmd_t            cmd_r;
  logic [ADDR_W-1:0]    pin_addr_r;
  logic [BANK_W-1:0]    pin_bank_r;
  logic                 dq_oe_r;

  // apb decode
  wire              setup  = i_psel & ~i_penable;
  wire              access = i_psel & i_penable & pready_r;
  wire              wr     = access & i_pwrite;
  wire              mapped = (i_paddr == REG_CMD) | (i_paddr == REG_ADDR) |
                             (i_paddr == REG_WDATA) | (i_paddr == REG_CKE) |
                             (i_paddr == REG_STAT) | (i_paddr == REG_RDATA);
  wire              busy   = wait_r != '0;
  sdcb_cmd_t        op;
  assign op = sdcb_cmd_t'(i_pwdata[2:0]);
  wire [BANK_W-1:0] op_bank = i_pwdata[CMD_BANK_LSB +: BANK_W];
  wire              op_sref = i_pwdata[CMD_SREF_BIT] & (op == CMD_REF);
  // refresh and mode load only with every bank idle
  wire              legal  = ~busy & cke_r & ~sref_r &
                             (((op != CMD_REF) & (op != CMD_LMR)) | (open_r == '0));
  wire              launch = wr & (i_paddr == REG_CMD) & legal;
  // power-down only from idle, no-op on the falling edge
  wire              cke_wr = wr & (i_paddr == REG_CKE) & ~busy & (open_r == '0);
  wire              cap    = rd_sh_r[2];
  wire [31:0]       rd_mux =
    (i_paddr == REG_ADDR)  ? 32'(addr_reg_r) :
    (i_paddr == REG_WDATA) ? {14'h0000, mask_r, wdata_r} :
    (i_paddr == REG_CKE)   ? 32'(cke_r) :
    (i_paddr == REG_STAT)  ? 32'({open_r, sref_r, cke_r, rvalid_r, busy}) :
    (i_paddr == REG_RDATA) ? 32'(rdata_r) : 32'h00000000;

  // apb answer one cycle after setup
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= '0;
    end else begin
      pready_r  <= setup;
      pslverr_r <= setup & ~mapped;
      prdata_r  <= setup ? rd_mux : prdata_r;
    end
  end

  // software registers and command launch
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      addr_reg_r <= '0;
      wdata_r    <= '0;
      mask_r     <= '0;
      cke_r      <= CKE_RST;
      sref_r     <= 1'b0;
      open_r     <= '0;
      wait_r     <= '0;
      cmd_r      <= CMD_NOP;
      pin_addr_r <= '0;
      pin_bank_r <= '0;
      dq_oe_r    <= 1'b0;
    end else begin
      // no-op on every edge while waiting
      cmd_r   <= launch ? op : CMD_NOP;
      // hold off every command until the wait of the launched command runs out
      wait_r  <= launch ? wait_of(op, addr_reg_r[AP_BIT]) : (busy ? wait_r - TMR_ONE : wait_r);
      dq_oe_r <= launch ? (op == CMD_WR) : (dq_oe_r & (wait_r > TMR_ONE));
      if (wr && (i_paddr == REG_ADDR)) begin
        addr_reg_r <= i_pwdata[ADDR_W-1:0];
      end
      if (wr && (i_paddr == REG_WDATA)) begin
        wdata_r <= i_pwdata[DQ_W-1:0];
        mask_r  <= i_pwdata[WD_MASK_LSB +: DQM_W];
      end
      if (launch) begin
        pin_addr_r <= addr_reg_r;
        pin_bank_r <= op_bank;
      end
      // bank open tracking
      if (launch && (op == CMD_ACT)) begin
        open_r[op_bank] <= 1'b1;
      end
      if (launch && (((op == CMD_PRE) && addr_reg_r[AP_BIT]))) begin
        open_r <= '0;
      end else if (launch && ((op == CMD_PRE) ||
                   (((op == CMD_RD) || (op == CMD_WR)) && addr_reg_r[AP_BIT]))) begin
        open_r[op_bank] <= 1'b0;
      end
      // refresh with enable dropped enters self refresh
      if (launch && op_sref) begin
        cke_r  <= 1'b0;
        sref_r <= 1'b1;
      end else if (wr && (i_paddr == REG_CKE) && sref_r && i_pwdata[0]) begin
        cke_r  <= 1'b1;
        sref_r <= 1'b0;
        wait_r <= SREX_CYC;
      end else if (cke_wr) begin
        cke_r <= i_pwdata[0];
      end
    end
  end

  // read return capture, cleared by reading the data
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      rd_sh_r  <= '0;
      rdata_r  <= '0;
      rvalid_r <= 1'b0;
    end else begin
      rd_sh_r  <= {rd_sh_r[1:0], launch & (op == CMD_RD)};
      rdata_r  <= cap ? bus.dq : rdata_r;
      rvalid_r <= cap | (rvalid_r & ~(access & ~i_pwrite & (i_paddr == REG_RDATA)));
    end
  end

  // outputs
  assign o_pready        = pready_r;
  assign o_pslverr       = pslverr_r;
  assign o_prdata        = prdata_r;
  // chip select low, strobes carry the command
  assign bus.cs_n        = 1'b0;
  assign {bus.ras_n, bus.cas_n, bus.we_n} = cmd_r;
  assign bus.cke         = cke_r;
  assign bus.addr        = pin_addr_r;
  assign bus.bank_select = pin_bank_r;
  assign bus.dqm         = mask_r;
  assign bus.ctl_dq      = wdata_r;
  assign bus.ctl_dq_oe   = dq_oe_r;
endmodule

// ==== dv/sdcb_checker.sv ====
`timescale 1ns/100ps
module sdcb_checker (
  // clock and reset
  input wire logic                      i_ref_clk,
  input wire logic                      i_reset,
  // command pins
  input wire logic                      cs_n,
  input wire logic                      ras_n,
  input wire logic                      cas_n,
  input wire logic                      we_n,
  input wire logic                      cke,
  // data lane control
  input wire logic [sdcb_pkg::DQM_W-1:0] dqm,
  input wire logic                      ctl_dq_oe,
  input wire logic [sdcb_pkg::DQM_W-1:0] dev_dq_oe
);
  import sdcb_pkg::*;
  // command code on the strobes
  wire logic [2:0] cmd = {ras_n, cas_n, we_n};
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  a_chip_sel_low: assert property (cs_n == 1'b0)
    else $error("chip select high");
  a_write_drive: assert property (cmd == CMD_WR |-> ctl_dq_oe [*4])
    else $error("write data not driven for the burst");
  a_read_mask: assert property (cmd == CMD_RD |-> ##[1:3] dev_dq_oe == ~dqm)
    else $error("read lanes do not follow mask");
  a_no_clash: assert property (dev_dq_oe != 2'h0 |-> !ctl_dq_oe)
    else $error("both ends drive data");
  a_hold_nop: assert property (!cke && !$past(cke) |-> cmd == CMD_NOP)
    else $error("command while clock disabled");
  a_exit_nop: assert property ($rose(cke) |-> (cmd == CMD_NOP) [*2])
    else $error("command too soon after wake");
  a_sref_hold: assert property (cmd == CMD_REF && !cke |=> !cke)
    else $error("self refresh left at once");
  a_busy_nop: assert property (cmd inside {CMD_REF, CMD_LMR} |=> cmd == CMD_NOP)
    else $error("command during global operation");
  a_act_wait: assert property (cmd == CMD_ACT |=> cmd == CMD_NOP)
    else $error("command during activate");
endmodule

// ==== dv/sdram_command_bank_fsm_test.sv ====
`timescale 1ns/100ps
module sdram_command_bank_fsm_test;
  import sdcb_pkg::*;
  // clock, reset, apb and device side signals
  logic i_ref_clk = 0, i_reset = 1, i_psel = 0, i_penable = 0, i_pwrite = 0;
  logic o_pready, o_pslverr, o_wr_stb, o_rd_stb, o_ref_stb, err;
  logic [7:0] i_paddr = 0;
  logic [31:0] i_pwdata = 0, o_prdata, rd;
  logic [15:0] i_rd_data = 16'h5A3C, o_wr_data;
  logic [11:0] o_acc_row, o_ref_row, o_mode, rrow;
  logic [7:0] o_acc_col;
  logic [1:0] o_acc_bank, o_wr_byte_en;
  logic [39:0] wcap;
  sdcb_pwr_t o_pwr;
  int n_mismatch = 0, checked = 0, nwr = 0, nrd = 0, nref = 0;
  sdcb_if bus ();
  sdcb_dev i_sdcb_dev (.i_ref_clk, .i_reset, .bus(bus), .o_wr_stb, .o_rd_stb, .o_acc_bank,
    .o_acc_row, .o_acc_col, .o_wr_data, .o_wr_byte_en, .i_rd_data, .o_ref_stb, .o_ref_row,
    .o_mode, .o_pwr);
  sdcb_ctl i_sdcb_ctl (.i_ref_clk, .i_reset, .i_psel, .i_penable, .i_pwrite, .i_paddr,
    .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .bus(bus));
  sdcb_checker i_sdcb_checker (.i_ref_clk, .i_reset, .cs_n(bus.cs_n), .ras_n(bus.ras_n),
    .cas_n(bus.cas_n), .we_n(bus.we_n), .cke(bus.cke), .dqm(bus.dqm),
    .ctl_dq_oe(bus.ctl_dq_oe), .dev_dq_oe(bus.dev_dq_oe));
  initial forever #50 i_ref_clk = ~i_ref_clk;
  // keep the last write beat seen at the array side
  always @(posedge i_ref_clk) if (o_wr_stb === 1'b1) begin
    wcap <= {o_acc_bank, o_acc_row, o_acc_col, o_wr_byte_en, o_wr_data};
    nwr <= nwr + 1;
  end
  // count read beats and accepted auto refreshes at the array side
  always @(posedge i_ref_clk) begin
    if (o_rd_stb === 1'b1) nrd <= nrd + 1;
    if (o_ref_stb === 1'b1) nref <= nref + 1;
  end
  task test_done;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= {2'b10, w, a, d};
    @(posedge i_ref_clk);
    i_penable <= 1'b1;
    do @(posedge i_ref_clk); while (o_pready !== 1'b1);
    {rd, err} = {o_prdata, o_pslverr};
    {i_psel, i_penable} <= 2'b00;
  endtask
  // issue one command and poll until the controller is free
  task automatic op(input logic [2:0] c, input logic [1:0] b, input logic [11:0] ad,
                    input logic s = 0);
    apb(1, REG_ADDR, {20'h0, ad});
    apb(1, REG_CMD, {23'h0, s, 2'h0, b, 1'h0, c});
    do apb(0, REG_STAT, 0); while (rd[0] !== 1'b0);
    repeat (4) @(posedge i_ref_clk);
  endtask
  task t_access;
    op(CMD_LMR, 0, 12'hA5C);
    chk("mode", 12'hA5C, o_mode);
    op(CMD_ACT, 2, 12'h123);
    apb(0, REG_STAT, 0);
    chk("open", 4'h4, rd[7:4]);
    apb(1, REG_WDATA, 32'h1BEEF);
    op(CMD_WR, 2, 12'h034);
    chk("beat", {2'h2, 12'h123, 8'h37, 2'h2, 16'hBEEF}, wcap);
    chk("beats", 4, nwr);
    apb(1, REG_WDATA, 0);
    op(CMD_RD, 2, 12'h434);
    apb(0, REG_RDATA, 0);
    chk("rdata", 16'h5A3C, rd);
    chk("read beats", BURST_LEN, nrd);
    apb(0, REG_STAT, 0);
    chk("open", 0, rd[7:4]);
  endtask
  task t_global;
    op(CMD_ACT, 1, 12'h0F0);
    op(CMD_ACT, 3, 12'hF0F);
    op(CMD_PRE, 0, 12'h400);
    apb(0, REG_STAT, 0);
    chk("open", 0, rd[7:4]);
    rrow = o_ref_row;
    op(CMD_REF, 0, 0);
    chk("ref row", rrow + 12'h1, o_ref_row);
    chk("refs", 1, nref);
    apb(0, 8'h20, 0);
    chk("slverr", 1, err);
  endtask
  task t_power;
    apb(1, REG_CKE, 0);
    repeat (3) @(posedge i_ref_clk);
    chk("down", PWR_DOWN, o_pwr);
    apb(1, REG_CKE, 1);
    repeat (3) @(posedge i_ref_clk);
    chk("run", PWR_RUN, o_pwr);
    op(CMD_REF, 0, 0, 1);
    chk("self", PWR_SELF, o_pwr);
    chk("refs", 1, nref);
    apb(1, REG_CKE, 1);
    repeat (4) @(posedge i_ref_clk);
    chk("run", PWR_RUN, o_pwr);
  endtask
  initial begin
    repeat (5) @(posedge i_ref_clk);
    i_reset <= 1'b0;
    t_access;
    t_global;
    t_power;
    test_done;
  end
  initial begin
    #2000000;
    n_mismatch++;
    test_done;
  end
endmodule
